// *** logic/srnv_pkg.sv ***
// Package of constants and types for the non-volatile status register one block.
package srnv_pkg;

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_READ_ANY_REG  = 8'h65;
  localparam logic [7:0] OPC_WRITE_ANY_REG = 8'h71;

  // ----------------------------------------------------------------------
  // Register addresses carried by the any-register commands
  // ----------------------------------------------------------------------
  localparam int          REG_ADDR_W       = 24;
  localparam logic [23:0] ADDR_STATUS_NV   = 24'h000000;
  localparam logic [23:0] ADDR_CONFIG_NV   = 24'h000002;
  localparam logic [23:0] ADDR_STATUS_VOL  = 24'h800000;
  localparam logic [23:0] ADDR_CONFIG_VOL  = 24'h800002;

  // ----------------------------------------------------------------------
  // Field positions of status register one
  // ----------------------------------------------------------------------
  localparam int LOCK_BIT = 7;
  localparam int PERR_BIT = 6;
  localparam int EERR_BIT = 5;
  localparam int BP_HI    = 4;
  localparam int BP_LO    = 2;
  localparam int WEL_BIT  = 1;
  localparam int WIP_BIT  = 0;

  // ----------------------------------------------------------------------
  // Shipped and default values
  // ----------------------------------------------------------------------
  localparam logic       SHIP_LOCK        = 1'b0;
  localparam logic [2:0] SHIP_BP          = 3'h0;
  localparam logic [2:0] BP_ALL_SET       = 3'h7;
  localparam logic       DEF_PROG_ERR     = 1'b0;
  localparam logic       DEF_ERASE_ERR    = 1'b0;
  localparam logic       DEF_WRITE_LATCH  = 1'b0;
  localparam logic       DEF_BUSY_FLAG    = 1'b0;

  // ----------------------------------------------------------------------
  // Timing of a non-volatile cell program at the 40 MHz clock
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ     = 40000;
  localparam int NV_PROG_TIME_NS  = 1000;
  localparam int NV_PROG_CYCLES   = (NV_PROG_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int ARRAY_ADDR_W     = 27;

  // ----------------------------------------------------------------------
  // Carrier types and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data;
  } srnv_cmd_t;

  typedef struct packed {
    logic                    is_bulk;
    logic [ARRAY_ADDR_W-1:0] addr;
  } srnv_array_req_t;

  typedef enum logic [0:0] {NV_IDLE, NV_PROG} srnv_nv_state_t;

endpackage : srnv_pkg

// *** logic/srnv_prot_range.sv ***
// Block-protection range check for array program and erase requests.
`timescale 1ns/1ps
module srnv_prot_range #(
  parameter int AW = 27
) (
  // Active protection field and request
  input  wire logic [2:0]    i_bp,
  input  wire logic          i_is_bulk,
  input  wire logic [AW-1:0] i_addr,
  // Verdict
  output logic               o_reject
);

  logic [AW-1:0] top_mask;
  logic          in_range;

  // Protected area is the top 1/2^(7-bp) of the array for bp of one to seven; bp of zero protects nothing, bp of seven covers it all.
  function automatic logic [AW-1:0] range_mask(input logic [2:0] bp);
    logic [AW-1:0] m;
    m = '0;
    for (int k = 0; k < 7; k++)
    begin
      if (k < (7 - int'(bp)))
      begin
        m[AW-1-k] = 1'b1;
      end
    end
    return m;
  endfunction : range_mask

  assign top_mask = range_mask(i_bp);
  assign in_range = (i_bp != 3'h0) && ((i_addr & top_mask) == top_mask);
  // Bulk erase needs every active bit clear; others only need to miss the range.
  assign o_reject = i_is_bulk ? (i_bp != 3'h0) : in_range;

endmodule : srnv_prot_range

// *** logic/srnv_status_nv.sv ***
// Non-volatile status register one with write lock, block protection and volatile copy.
`timescale 1ns/1ps
module srnv_status_nv #(
  parameter int PROG_CYCLES = srnv_pkg::NV_PROG_CYCLES,
  parameter int AW          = srnv_pkg::ARRAY_ADDR_W
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_soft_reset,
  // Register command from the command decoder
  input  wire logic                     i_cmd_valid,
  input  wire srnv_pkg::srnv_cmd_t      i_cmd,
  // State of the surrounding device
  input  wire logic                     i_write_enable_latch,
  input  wire logic                     i_operation_busy_flag,
  input  wire logic                     i_block_prot_volatile_select,
  input  wire logic                     i_write_protect_n,
  // Error events and clear
  input  wire logic                     i_prog_err_set,
  input  wire logic                     i_erase_err_set,
  input  wire logic                     i_clear_status,
  // Array program and erase requests
  input  wire logic                     i_array_valid,
  input  wire srnv_pkg::srnv_array_req_t i_array_req,
  // Register command answers
  output logic                          o_rd_valid,
  output logic [7:0]                    o_rd_data,
  output logic                          o_wr_done,
  output logic                          o_wr_ignored,
  output logic                          o_cfg_wr_allow,
  output logic                          o_other_wr_allow,
  // Array request answers
  output logic                          o_array_grant,
  output logic                          o_array_reject,
  // Register state
  output logic                          o_nv_busy,
  output logic                          o_hw_protected,
  output logic [2:0]                    o_bp_active,
  output logic [7:0]                    o_status_one_nonvolatile,
  output logic [7:0]                    o_status_one_volatile
);
  import srnv_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic           status_write_lock_nv;
  logic [2:0]     block_prot_nv;
  logic           status_write_lock_copy;
  logic [2:0]     block_prot_vol;
  logic           prog_err_flag;
  logic           erase_err_flag;
  srnv_nv_state_t nv_state;
  logic [15:0]    prog_count;
  logic           pend_lock;
  logic [2:0]     pend_bp;
  logic           pend_copy_bp;
  logic           wp_n_sync;

  // ----------------------------------------------------------------------
  // Pin synchronisation and submodules
  // ----------------------------------------------------------------------
  // The write-protect pin is asynchronous to the clock.
  srnv_sync2 #(
    .W       (1)
  ) u_wp_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_write_protect_n),
    .o_sync  (wp_n_sync)
  );

  logic range_reject;

  srnv_prot_range #(
    .AW        (AW)
  ) u_prot (
    .i_bp      (o_bp_active),
    .i_is_bulk (i_array_req.is_bulk),
    .i_addr    (i_array_req.addr),
    .o_reject  (range_reject)
  );

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire is_read     = i_cmd_valid && (i_cmd.opcode == OPC_READ_ANY_REG);
  wire is_write    = i_cmd_valid && (i_cmd.opcode == OPC_WRITE_ANY_REG);
  wire tgt_stat_nv = (i_cmd.addr == ADDR_STATUS_NV);
  wire tgt_stat_v  = (i_cmd.addr == ADDR_STATUS_VOL);
  wire tgt_cfg     = (i_cmd.addr == ADDR_CONFIG_NV) || (i_cmd.addr == ADDR_CONFIG_VOL);
  wire tgt_locked  = tgt_stat_nv || tgt_stat_v || tgt_cfg;
  wire vol_mode    = i_block_prot_volatile_select;
  wire nv_idle     = (nv_state == NV_IDLE);

  // Lock set and pin low: protected; pin high or lock clear: writes pass.
  wire hw_protect  = status_write_lock_nv && !wp_n_sync;

  // Only the four status and configuration registers are gated by the pin.
  wire blocked     = hw_protect && tgt_locked;

  // A status or configuration write needs the latch set and no non-volatile program under way, since
  // overlapping programs would leave the cell value undefined.
  wire wr_ok       = is_write && i_write_enable_latch && nv_idle && !blocked;

  wire wr_stat_nv  = wr_ok && tgt_stat_nv;
  wire wr_stat_v   = wr_ok && tgt_stat_v;
  wire wr_cfg      = wr_ok && tgt_cfg;
  wire wr_other    = is_write && !tgt_locked && i_write_enable_latch;
  wire wr_refused  = is_write && tgt_locked && !wr_ok;

  // In volatile mode the non-volatile protection bits must read all ones.
  wire need_bp_set = vol_mode && (block_prot_nv != BP_ALL_SET) && nv_idle
                     && !wr_stat_nv;

  // Non-volatile write: in volatile mode the protection field is refused.
  wire [2:0] wr_bp = vol_mode ? block_prot_nv : i_cmd.data[BP_HI:BP_LO];

  // ----------------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------------
  // Read-only default bits come from constants, so no write can reach them.
  wire [7:0] image_nv = {status_write_lock_nv,
                         DEF_PROG_ERR,
                         DEF_ERASE_ERR,
                         block_prot_nv,
                         DEF_WRITE_LATCH,
                         DEF_BUSY_FLAG};

  wire [7:0] image_v  = {status_write_lock_copy,
                         prog_err_flag,
                         erase_err_flag,
                         block_prot_vol,
                         i_write_enable_latch,
                         i_operation_busy_flag | !nv_idle};

  // The copy that governs protection depends on the configuration bit.
  assign o_bp_active    = vol_mode ? block_prot_vol : block_prot_nv;
  assign o_hw_protected = hw_protect;
  assign o_nv_busy      = !nv_idle;
  assign o_status_one_nonvolatile = image_nv;
  assign o_status_one_volatile    = image_v;

  // ----------------------------------------------------------------------
  // Non-volatile program sequencer
  // ----------------------------------------------------------------------
  wire prog_end = (nv_state == NV_PROG) && (prog_count == 16'h0000);

  // A program holds the new value aside and commits it after the cell time.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      nv_state     <= NV_IDLE;
      prog_count   <= 16'h0000;
      pend_lock    <= SHIP_LOCK;
      pend_bp      <= SHIP_BP;
      pend_copy_bp <= 1'b0;
    end
    else
    begin
      unique case (nv_state)
        NV_IDLE:
        begin
          if (wr_stat_nv)
          begin
            nv_state     <= NV_PROG;
            prog_count   <= 16'(PROG_CYCLES - 1);
            pend_lock    <= i_cmd.data[LOCK_BIT];
            pend_bp      <= wr_bp;
            pend_copy_bp <= !vol_mode;
          end
          else if (need_bp_set)
          begin
            nv_state     <= NV_PROG;
            prog_count   <= 16'(PROG_CYCLES - 1);
            pend_lock    <= status_write_lock_nv;
            pend_bp      <= BP_ALL_SET;
            pend_copy_bp <= 1'b0;
          end
        end
        NV_PROG:
        begin
          if (prog_end)
          begin
            nv_state <= NV_IDLE;
          end
          else
          begin
            prog_count <= prog_count - 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Non-volatile cells and lock mirror
  // ----------------------------------------------------------------------
  // The hard reset stands for a fresh shipped part; soft reset keeps the cells.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      status_write_lock_nv   <= SHIP_LOCK;
      block_prot_nv          <= SHIP_BP;
      status_write_lock_copy <= SHIP_LOCK;
    end
    else if (prog_end)
    begin
      status_write_lock_nv   <= pend_lock;
      block_prot_nv          <= pend_bp;
      status_write_lock_copy <= pend_lock;
    end
    else if (i_soft_reset)
    begin
      status_write_lock_copy <= status_write_lock_nv;
    end
  end

  // ----------------------------------------------------------------------
  // Volatile protection bits
  // ----------------------------------------------------------------------
  // In non-volatile mode the volatile bits only follow the cells; in volatile
  // mode a write to the volatile register changes them at once.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      block_prot_vol <= SHIP_BP;
    end
    else if (i_soft_reset)
    begin
      block_prot_vol <= block_prot_nv;
    end
    else if (prog_end && pend_copy_bp)
    begin
      block_prot_vol <= pend_bp;
    end
    else if (wr_stat_v && vol_mode)
    begin
      block_prot_vol <= i_cmd.data[BP_HI:BP_LO];
    end
  end

  // ----------------------------------------------------------------------
  // Volatile error flags
  // ----------------------------------------------------------------------
  // A set arriving with a clear wins, so no error is lost; reset reloads the
  // defaults held in the non-volatile read-only bits.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prog_err_flag  <= DEF_PROG_ERR;
      erase_err_flag <= DEF_ERASE_ERR;
    end
    else if (i_soft_reset)
    begin
      prog_err_flag  <= DEF_PROG_ERR;
      erase_err_flag <= DEF_ERASE_ERR;
    end
    else
    begin
      prog_err_flag  <= i_prog_err_set  || (prog_err_flag  && !i_clear_status);
      erase_err_flag <= i_erase_err_set || (erase_err_flag && !i_clear_status);
    end
  end

  // ----------------------------------------------------------------------
  // Command answers
  // ----------------------------------------------------------------------
  // Answers are registered one cycle after the command is taken.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_valid       <= 1'b0;
      o_rd_data        <= 8'h00;
      o_wr_done        <= 1'b0;
      o_wr_ignored     <= 1'b0;
      o_cfg_wr_allow   <= 1'b0;
      o_other_wr_allow <= 1'b0;
    end
    else
    begin
      o_rd_valid       <= is_read && (tgt_stat_nv || tgt_stat_v);
      o_rd_data        <= tgt_stat_nv ? image_nv : image_v;
      o_wr_done        <= wr_stat_v;
      o_wr_ignored     <= wr_refused;
      o_cfg_wr_allow   <= wr_cfg;
      o_other_wr_allow <= wr_other;
    end
  end

  // ----------------------------------------------------------------------
  // Array request verdict
  // ----------------------------------------------------------------------
  // The verdict uses the protection copy in force at the request cycle.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_array_grant  <= 1'b0;
      o_array_reject <= 1'b0;
    end
    else
    begin
      o_array_grant  <= i_array_valid && !range_reject;
      o_array_reject <= i_array_valid && range_reject;
    end
  end

  // ----------------------------------------------------------------------
  // Completion of a non-volatile write
  // ----------------------------------------------------------------------
  // Completion of a non-volatile write is reported by the busy output falling;
  // the flag here stands high from the write being taken to the program end and drives no output.
  logic prog_done_user;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prog_done_user <= 1'b0;
    end
    else if (wr_stat_nv)
    begin
      prog_done_user <= 1'b1;
    end
    else if (prog_end)
    begin
      prog_done_user <= 1'b0;
    end
  end

endmodule : srnv_status_nv

// *** logic/srnv_sync2.sv ***
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module srnv_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // The first stage is read only by the second stage, never by logic.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta   <= '1;
      o_sync <= '1;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : srnv_sync2

// *** testbench/srnv_host.sv ***
// Host controller model that issues any-register commands to the block.
`timescale 1ns/1ps
module srnv_host (
  // Clock
  input  wire logic          i_clk,
  // Command towards the block
  output logic               o_cmd_valid,
  output srnv_pkg::srnv_cmd_t o_cmd
);
  import srnv_pkg::*;

  // Bus starts idle.
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd       = '0;
  end

  // One command stands for exactly one edge; afterwards the fields show the
  // inverse of the last command, so stale fields are never mistaken for one.
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd       <= {op, a, d};
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_cmd       <= ~{op, a, d};
  endtask : send
endmodule : srnv_host

// *** testbench/srnv_status_nv_monitor.sv ***
// Checker of the status register one block, bound to its top module.
`timescale 1ns/1ps
module srnv_status_nv_monitor #(
  parameter int PROG_CYCLES = 2
) (
  // Clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  // Inputs watched
  input wire logic                     i_cmd_valid,
  input wire srnv_pkg::srnv_cmd_t      i_cmd,
  input wire logic                     i_write_enable_latch,
  input wire logic                     i_block_prot_volatile_select,
  input wire logic                     i_array_valid,
  input wire srnv_pkg::srnv_array_req_t i_array_req,
  // Outputs watched
  input wire logic                     o_rd_valid,
  input wire logic [7:0]               o_rd_data,
  input wire logic                     o_wr_done,
  input wire logic                     o_wr_ignored,
  input wire logic                     o_other_wr_allow,
  input wire logic                     o_array_grant,
  input wire logic                     o_array_reject,
  input wire logic                     o_nv_busy,
  input wire logic                     o_hw_protected,
  input wire logic [2:0]               o_bp_active,
  input wire logic [7:0]               o_status_one_nonvolatile,
  input wire logic [7:0]               o_status_one_volatile
);
  import srnv_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Command decode; busy is excluded so a finishing program cannot mask a fault.
  wire logic       wr     = i_cmd_valid && i_cmd.opcode == OPC_WRITE_ANY_REG;
  wire logic       wr_ok  = wr && i_write_enable_latch && !o_nv_busy;
  wire logic       rd_nv  = i_cmd_valid && i_cmd.opcode == OPC_READ_ANY_REG
                            && i_cmd.addr == ADDR_STATUS_NV;
  wire logic       st_reg = i_cmd.addr == ADDR_STATUS_NV || i_cmd.addr == ADDR_CONFIG_NV
                            || i_cmd.addr == ADDR_STATUS_VOL || i_cmd.addr == ADDR_CONFIG_VOL;
  wire logic [2:0] cmd_bp = i_cmd.data[4:2];
  wire logic [2:0] nv_bp  = o_status_one_nonvolatile[4:2];
  wire logic [2:0] vol_bp = o_status_one_volatile[4:2];

  a_read_answer: assert property (rd_nv && !o_nv_busy |=> o_rd_valid
    && o_rd_data == $past(o_status_one_nonvolatile)) else $error("read answer wrong");
  a_protect_ignore: assert property (wr && st_reg && o_hw_protected && !o_nv_busy
    |=> o_wr_ignored && !o_nv_busy && $stable(o_status_one_nonvolatile))
    else $error("protected write not ignored");
  a_accept_unlocked: assert property (wr_ok && i_cmd.addr == ADDR_STATUS_VOL
    && !o_hw_protected |=> o_wr_done && !o_wr_ignored) else $error("write refused");
  a_other_free: assert property (wr && i_write_enable_latch && !st_reg
    |=> o_other_wr_allow) else $error("other write blocked");
  a_lock_mirror: assert property (o_status_one_volatile[7]
    == o_status_one_nonvolatile[7]) else $error("lock copy differs");
  a_fixed_bits: assert property ((o_status_one_nonvolatile & 8'h63) == 8'h00)
    else $error("default bit nonzero");
  a_nv_copy: assert property ($fell(o_nv_busy) && !i_block_prot_volatile_select
    |-> vol_bp == nv_bp) else $error("bp copy missing");
  a_vol_only: assert property (wr_ok && i_cmd.addr == ADDR_STATUS_VOL
    && i_block_prot_volatile_select && !o_hw_protected
    |=> vol_bp == $past(cmd_bp) && $stable(nv_bp)) else $error("volatile bp write wrong");
  a_bp_select: assert property (o_bp_active
    == (i_block_prot_volatile_select ? vol_bp : nv_bp)) else $error("active bp wrong");
  a_bulk_gate: assert property (i_array_valid && i_array_req.is_bulk
    |=> o_array_reject == ($past(o_bp_active) != 3'h0) && o_array_grant != o_array_reject)
    else $error("bulk erase gate wrong");

  // Main scenarios reached.
  c_ignored: cover property (o_wr_ignored);
  c_reject: cover property (o_array_reject);
  c_program: cover property ($fell(o_nv_busy));
endmodule : srnv_status_nv_monitor

bind srnv_status_nv srnv_status_nv_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_mon (.i_clk, .i_rst,
  .i_cmd_valid, .i_cmd, .i_write_enable_latch, .i_block_prot_volatile_select, .i_array_valid,
  .i_array_req, .o_rd_valid, .o_rd_data, .o_wr_done, .o_wr_ignored, .o_other_wr_allow,
  .o_array_grant, .o_array_reject, .o_nv_busy, .o_hw_protected, .o_bp_active,
  .o_status_one_nonvolatile, .o_status_one_volatile);

// *** testbench/tb.sv ***
// Self-checking testbench of the status register one block.
`timescale 1ns/1ps
module tb;
  import srnv_pkg::*;
  localparam int PROG = 2;
  logic i_clk = 1'b0, i_rst = 1'b1, i_soft_reset = 1'b0, i_write_enable_latch = 1'b1;
  logic i_operation_busy_flag = 1'b0, i_block_prot_volatile_select = 1'b0;
  logic i_write_protect_n = 1'b1, i_array_valid = 1'b0;
  logic i_prog_err_set = 1'b0, i_erase_err_set = 1'b0, i_clear_status = 1'b0;
  srnv_array_req_t i_array_req = '0;
  srnv_cmd_t i_cmd;
  logic i_cmd_valid;
  wire logic o_rd_valid, o_wr_done, o_wr_ignored, o_cfg_wr_allow, o_other_wr_allow;
  wire logic o_array_grant, o_array_reject, o_nv_busy, o_hw_protected;
  wire logic [2:0] o_bp_active;
  wire logic [7:0] o_rd_data, o_status_one_nonvolatile, o_status_one_volatile;
  int bad_count = 0;
  int checks = 0;

  always #12.5 i_clk = ~i_clk;

  srnv_host i_host (.i_clk, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));
  srnv_status_nv #(.PROG_CYCLES(PROG)) i_dut (.i_clk, .i_rst, .i_soft_reset, .i_cmd_valid,
    .i_cmd, .i_write_enable_latch, .i_operation_busy_flag, .i_block_prot_volatile_select,
    .i_write_protect_n, .i_prog_err_set, .i_erase_err_set, .i_clear_status, .i_array_valid,
    .i_array_req, .o_rd_valid, .o_rd_data, .o_wr_done, .o_wr_ignored, .o_cfg_wr_allow,
    .o_other_wr_allow, .o_array_grant, .o_array_reject, .o_nv_busy, .o_hw_protected,
    .o_bp_active, .o_status_one_nonvolatile, .o_status_one_volatile);

  // --------------------
  // Shared tasks
  // --------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Answers stand one cycle, so they are looked at just after the taking edge.
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    i_host.send(op, a, d);
    #1;
  endtask : cmd

  task automatic wait_idle();
    for (int n = 0; n < 100 && o_nv_busy !== 1'b0; n++)
    begin
      @(posedge i_clk);
      #1;
    end
    chk("program ends", 8'h00, {7'h0, o_nv_busy});
  endtask : wait_idle

  task automatic nv_write(input logic [7:0] d);
    cmd(OPC_WRITE_ANY_REG, ADDR_STATUS_NV, d);
    chk("program starts", 8'h01, {7'h0, o_nv_busy});
    wait_idle();
  endtask : nv_write

  // Pin changes pass a two stage synchroniser, hence the settling cycles.
  task automatic set_pin(input logic v);
    @(posedge i_clk);
    i_write_protect_n <= v;
    repeat (3) @(posedge i_clk);
  endtask : set_pin

  task automatic arr(input logic bulk, input logic [26:0] a, input logic rej);
    @(posedge i_clk);
    i_array_valid <= 1'b1;
    i_array_req   <= {bulk, a};
    @(posedge i_clk);
    i_array_valid <= 1'b0;
    #1;
    chk("array reject", {7'h0, rej}, {7'h0, o_array_reject});
    chk("array grant", {7'h0, !rej}, {7'h0, o_array_grant});
  endtask : arr

  // --------------------
  // Scenarios
  // --------------------
  task automatic s_ship_and_copy();
    cmd(OPC_READ_ANY_REG, ADDR_STATUS_NV, 8'h00);
    chk("read valid", 8'h01, {7'h0, o_rd_valid});
    chk("shipped image", {SHIP_LOCK, 2'b00, SHIP_BP, 2'b00}, o_rd_data);
    nv_write(8'hff);
    chk("nv image", 8'h9c, o_status_one_nonvolatile);
    chk("vol lock and bp", 8'h9c, o_status_one_volatile & 8'h9c);
  endtask : s_ship_and_copy

  task automatic s_protect();
    set_pin(1'b0);
    #1;
    chk("protected", 8'h01, {7'h0, o_hw_protected});
    cmd(OPC_WRITE_ANY_REG, ADDR_STATUS_NV, 8'h00);
    chk("status refused", 8'h01, {7'h0, o_wr_ignored});
    cmd(OPC_WRITE_ANY_REG, ADDR_CONFIG_VOL, 8'h00);
    chk("config refused", 8'h01, {7'h0, o_wr_ignored});
    chk("config held", 8'h00, {7'h0, o_cfg_wr_allow});
    chk("image kept", 8'h9c, o_status_one_nonvolatile);
    cmd(OPC_WRITE_ANY_REG, 24'h000003, 8'h00);
    chk("other write", 8'h01, {7'h0, o_other_wr_allow});
    set_pin(1'b1);
    cmd(OPC_WRITE_ANY_REG, ADDR_CONFIG_NV, 8'h00);
    chk("pin high config", 8'h01, {7'h0, o_cfg_wr_allow});
    nv_write(8'h10);
    chk("pin high write", 8'h10, o_status_one_nonvolatile);
    set_pin(1'b0);
    cmd(OPC_WRITE_ANY_REG, ADDR_CONFIG_VOL, 8'h00);
    chk("unlocked config", 8'h01, {7'h0, o_cfg_wr_allow});
    nv_write(8'h14);
    chk("unlocked write", 8'h14, o_status_one_nonvolatile);
  endtask : s_protect

  task automatic s_array();
    arr(1'b1, 27'h0000000, 1'b1);
    arr(1'b0, 27'h7ffffff, 1'b1);
    arr(1'b0, 27'h0000000, 1'b0);
    nv_write(8'h00);
    arr(1'b1, 27'h0000000, 1'b0);
  endtask : s_array

  task automatic s_volatile();
    @(posedge i_clk);
    i_block_prot_volatile_select <= 1'b1;
    repeat (PROG + 4) @(posedge i_clk);
    #1;
    wait_idle();
    chk("nv bp forced", 8'h1c, o_status_one_nonvolatile);
    cmd(OPC_WRITE_ANY_REG, ADDR_STATUS_VOL, 8'h0c);
    chk("vol write done", 8'h01, {7'h0, o_wr_done});
    chk("vol bp", 8'h0c, o_status_one_volatile & 8'h1c);
    chk("active bp", 8'h03, {5'h0, o_bp_active});
    nv_write(8'h00);
    chk("nv bp locked", 8'h1c, o_status_one_nonvolatile);
  endtask : s_volatile

  // Error flags are seeded from the fixed default bits; a set beats a clear.
  task automatic s_flags();
    @(posedge i_clk);
    i_prog_err_set  <= 1'b1;
    i_erase_err_set <= 1'b1;
    @(posedge i_clk);
    i_prog_err_set  <= 1'b0;
    i_erase_err_set <= 1'b0;
    cmd(OPC_READ_ANY_REG, ADDR_STATUS_VOL, 8'h00);
    chk("vol read", 8'h01, {7'h0, o_rd_valid});
    chk("flags set", 8'h60, o_rd_data & 8'h60);
    chk("nv defaults", 8'h00, o_status_one_nonvolatile & 8'h63);
    @(posedge i_clk);
    i_clear_status  <= 1'b1;
    i_erase_err_set <= 1'b1;
    @(posedge i_clk);
    i_clear_status  <= 1'b0;
    i_erase_err_set <= 1'b0;
    #1;
    chk("set beats clear", 8'h20, o_status_one_volatile & 8'h60);
    @(posedge i_clk);
    i_soft_reset <= 1'b1;
    @(posedge i_clk);
    i_soft_reset <= 1'b0;
    #1;
    chk("flags reloaded", 8'h00, o_status_one_volatile & 8'h60);
    chk("lock copy", 8'h00, o_status_one_volatile & 8'h80);
  endtask : s_flags

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Main sequence after a ten cycle reset.
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    s_ship_and_copy();
    s_protect();
    s_array();
    s_volatile();
    s_flags();
    report_and_stop();
  end

  // The run needs well under a thousand cycles; four thousand marks a hang.
  initial
  begin
    #(25 * 4000);
    bad_count++;
    report_and_stop();
  end
endmodule : tb
